// ### core/srw_pkg.sv
// srw_pkg.sv: types for the supervisor block
// assumes srw_regs.svh holds the numeric constants
`default_nettype none
package srw_pkg;
  typedef enum logic [1:0] {SRW_RUN, SRW_HOLD, SRW_TIMEOUT} srw_state_e;
  typedef logic [15:0] srw_ms_t;
endpackage
`default_nettype wire

// ### core/srw_regs.svh
// srw_regs.svh: timing counts and widths for the supervisor block
// assumes a 100 MHz core clock; included by the design
`ifndef SRW_REGS_SVH
`define SRW_REGS_SVH
`define SRW_CLK_HZ            100000000
`define SRW_TICK_HZ           1000
`define SRW_PRESCALE          (`SRW_CLK_HZ / `SRW_TICK_HZ)
`define SRW_PURST_MS          200
`define SRW_WDOG_MS           1600
`define SRW_PROG_MS           10
`define SRW_GLITCH_NS         100
`define SRW_CLK_NS            10
`define SRW_GLITCH_CYC        ((`SRW_GLITCH_NS + `SRW_CLK_NS - 1) / `SRW_CLK_NS)
`define SRW_SETTLE_CYC        (`SRW_GLITCH_CYC + 4)
`define SRW_RPD_US            5
`define SRW_RPD_CYC           ((`SRW_RPD_US * 1000) / `SRW_CLK_NS)
`endif

// ### core/srw_supervisor.sv
// srw_supervisor.sv: reset supervisor, watchdog and memory write gate
// assumes supply_good comes from an async comparator; pins are async
// Function
// RQ1: both resets asserted while supply below threshold, also at power-down
// RQ2: resets held for the power-up timeout after supply rises
// RQ3: after timeout the outputs stop driving; resistors set idle level
// RQ4: rising edge on the high reset pin restarts a full timeout
// RQ5: falling edge on the low reset pin restarts a full timeout
// RQ6: external reset level on either pin holds the reset condition
// RQ7: watchdog with no input transition for its period triggers reset
// RQ8: any watchdog input edge clears the count; host must toggle it
// RQ9: watchdog counter held at zero while reset asserted
// RQ10: reset input pulses up to the glitch width are ignored
// RQ11: output change starts within 5 us of threshold crossing
// RQ12: protect pin high makes the array read only
// RQ13: protect pin low allows normal reads and writes
// RQ14: supply below threshold inhibits every write
// RQ15: no access recognised and no acknowledge while reset active
// RQ16: internal program cycle of at most 10 ms disables the bus
// RQ17: host waits 1 ms after stable supply before any access
// RQ18: protected writes still acknowledge addresses, not first data byte
// RQ19: supply-good synchronised, timeouts counted by a prescaler
`include "srw_regs.svh"
`default_nettype none
module srw_supervisor #(
  parameter int unsigned PRESCALE   = `SRW_PRESCALE,
  parameter int unsigned PURST_MS   = `SRW_PURST_MS,
  parameter int unsigned WDOG_MS    = `SRW_WDOG_MS,
  parameter int unsigned PROG_MS    = `SRW_PROG_MS
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic supply_good,
  input  wire logic rst_hi_in,
  output logic      rst_hi_out,
  output logic      rst_hi_oe,
  input  wire logic rst_lo_n_in,
  output logic      rst_lo_n_out,
  output logic      rst_lo_n_oe,
  input  wire logic watchdog_kick_input,
  input  wire logic write_protect,
  input  wire logic mem_stop_write,
  input  wire logic mem_data_byte,
  output logic      mem_access_ok,
  output logic      mem_data_ack_ok,
  output logic      mem_write_ok,
  output logic      mem_busy
);
  import srw_pkg::*;

  localparam int unsigned GLITCH_CYC = `SRW_GLITCH_CYC;
  localparam int unsigned GW = $clog2(GLITCH_CYC + 2);
  localparam int unsigned PW = $clog2(PRESCALE + 1);

  // two-flop synchronisers for async pins
  logic [1:0] sup_sync_reg, hi_sync_reg, lo_sync_reg, wdi_sync_reg;
  logic [1:0] wp_sync_reg;
  logic [3:0] sync_next;
  logic [1:0] wp_next;
  always_comb begin
    sync_next = {supply_good, rst_hi_in, rst_lo_n_in, watchdog_kick_input};
    wp_next   = {wp_sync_reg[0], write_protect};
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sup_sync_reg <= 2'h0;
      hi_sync_reg  <= 2'h0;
      lo_sync_reg  <= 2'h3;
      wdi_sync_reg <= 2'h0;
      wp_sync_reg  <= 2'h3;
    end else begin
      sup_sync_reg <= {sup_sync_reg[0], sync_next[3]}; // RQ19 RQ11
      hi_sync_reg  <= {hi_sync_reg[0], sync_next[2]};
      lo_sync_reg  <= {lo_sync_reg[0], sync_next[1]};
      wdi_sync_reg <= {wdi_sync_reg[0], sync_next[0]};
      wp_sync_reg  <= wp_next;
    end
  end
  logic sup_ok, hi_s, lo_n_s, wdi_s, wp_s;
  always_comb begin
    sup_ok = sup_sync_reg[1];
    hi_s   = hi_sync_reg[1];
    lo_n_s = lo_sync_reg[1];
    wdi_s  = wdi_sync_reg[1];
    wp_s   = wp_sync_reg[1];
  end

  // glitch filters on the reset pins; unfiltered edge detect on the watchdog line
  logic [GW-1:0] hi_cnt_reg, hi_cnt_next, lo_cnt_reg, lo_cnt_next;
  logic          hi_flt_reg, hi_flt_next, lo_flt_reg, lo_flt_next;
  logic          wdi_prev_reg;
  always_comb begin
    hi_cnt_next = '0;
    hi_flt_next = hi_flt_reg;
    if (hi_s != hi_flt_reg) begin
      if (hi_cnt_reg == GW'(GLITCH_CYC)) begin
        hi_flt_next = hi_s; // RQ10
      end else begin
        hi_cnt_next = hi_cnt_reg + GW'(1);
      end
    end
    lo_cnt_next = '0;
    lo_flt_next = lo_flt_reg;
    if (lo_n_s != lo_flt_reg) begin
      if (lo_cnt_reg == GW'(GLITCH_CYC)) begin
        lo_flt_next = lo_n_s; // RQ10
      end else begin
        lo_cnt_next = lo_cnt_reg + GW'(1);
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hi_cnt_reg   <= '0;
      lo_cnt_reg   <= '0;
      hi_flt_reg   <= 1'b0;
      lo_flt_reg   <= 1'b1;
      wdi_prev_reg <= 1'b0;
    end else begin
      hi_cnt_reg   <= hi_cnt_next;
      lo_cnt_reg   <= lo_cnt_next;
      hi_flt_reg   <= hi_flt_next;
      lo_flt_reg   <= lo_flt_next;
      wdi_prev_reg <= wdi_s;
    end
  end

  // own drive reads back through the pin: masked while driven and settling
  localparam int unsigned SETTLE = `SRW_SETTLE_CYC;
  localparam int unsigned SW     = $clog2(SETTLE + 1);
  logic [SW-1:0] hi_set_reg, hi_set_next, lo_set_reg, lo_set_next;
  logic          ext_hi_reg, ext_hi_next, ext_lo_reg, ext_lo_next;
  logic hi_ext, lo_ext, hi_rise, lo_fall, wdi_edge, hi_mask, lo_mask;
  always_comb begin
    hi_mask     = rst_hi_oe || hi_set_reg != '0;
    lo_mask     = rst_lo_n_oe || lo_set_reg != '0;
    hi_ext      = hi_flt_next && !hi_mask; // RQ6
    lo_ext      = !lo_flt_next && !lo_mask; // RQ6
    hi_rise     = hi_flt_next && !hi_flt_reg && !hi_mask; // RQ4
    lo_fall     = !lo_flt_next && lo_flt_reg && !lo_mask; // RQ5
    wdi_edge    = wdi_s != wdi_prev_reg; // RQ8
    // with supply good, a pin the outside holds active is left undriven to see its release
    ext_hi_next = hi_ext && sup_ok;
    ext_lo_next = lo_ext && sup_ok;
    hi_set_next = rst_hi_oe ? SW'(SETTLE)
                            : hi_set_reg - SW'(hi_set_reg != '0);
    lo_set_next = rst_lo_n_oe ? SW'(SETTLE)
                              : lo_set_reg - SW'(lo_set_reg != '0);
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      hi_set_reg <= '0;
      lo_set_reg <= '0;
      ext_hi_reg <= 1'b0;
      ext_lo_reg <= 1'b0;
    end else begin
      hi_set_reg <= hi_set_next;
      lo_set_reg <= lo_set_next;
      ext_hi_reg <= ext_hi_next;
      ext_lo_reg <= ext_lo_next;
    end
  end

  // millisecond tick prescaler
  logic [PW-1:0] pre_reg, pre_next;
  logic          tick;
  always_comb begin
    tick     = pre_reg == PW'(PRESCALE - 1);
    pre_next = tick ? '0 : pre_reg + PW'(1); // RQ19
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_next;
    end
  end

  // reset state machine and watchdog
  srw_state_e st_reg, st_next;
  srw_ms_t    tmo_reg, tmo_next, wd_reg, wd_next;
  logic       rst_act;
  always_comb begin
    st_next  = st_reg;
    tmo_next = tmo_reg;
    wd_next  = wd_reg;
    unique case (st_reg)
      SRW_HOLD: begin
        tmo_next = '0;
        if (sup_ok && !hi_ext && !lo_ext) begin
          st_next = SRW_TIMEOUT;
        end
      end
      SRW_TIMEOUT: begin
        if (tick) begin
          tmo_next = tmo_reg + srw_ms_t'(1);
        end
        if (tick && tmo_reg == srw_ms_t'(PURST_MS - 1)) begin
          st_next = SRW_RUN; // RQ2
        end
      end
      SRW_RUN: begin
        if (wdi_edge) begin
          wd_next = '0; // RQ8
        end else if (tick) begin
          wd_next = wd_reg + srw_ms_t'(1);
        end
        if (!wdi_edge && tick && wd_reg == srw_ms_t'(WDOG_MS - 1)) begin
          st_next  = SRW_TIMEOUT; // RQ7
          tmo_next = '0;
        end
      end
    endcase
    if (hi_rise || lo_fall) begin
      st_next  = SRW_TIMEOUT; // RQ4 RQ5
      tmo_next = '0;
    end
    if (!sup_ok || hi_ext || lo_ext) begin
      st_next = SRW_HOLD; // RQ1 RQ6
    end
    if (st_next != SRW_RUN) begin
      wd_next = '0; // RQ9
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_reg  <= SRW_HOLD;
      tmo_reg <= '0;
      wd_reg  <= '0;
    end else begin
      st_reg  <= st_next;
      tmo_reg <= tmo_next;
      wd_reg  <= wd_next;
    end
  end

  // open-drain drive: active level only
  always_comb begin
    rst_act      = st_reg != SRW_RUN;
    rst_hi_out   = 1'b1; // RQ3
    rst_hi_oe    = rst_act && !ext_hi_reg; // RQ6
    rst_lo_n_out = 1'b0;
    rst_lo_n_oe  = rst_act && !ext_lo_reg; // RQ6
  end

  // memory gating and internal program cycle
  logic          prog_reg, prog_next;
  srw_ms_t       prog_cnt_reg, prog_cnt_next;
  logic          gate;
  always_comb begin
    prog_next     = prog_reg;
    prog_cnt_next = prog_cnt_reg;
    gate          = !rst_act && !hi_ext && !lo_ext && sup_ok; // RQ15 RQ14
    if (prog_reg) begin
      if (tick) begin
        prog_cnt_next = prog_cnt_reg + srw_ms_t'(1);
      end
      if (tick && prog_cnt_reg == srw_ms_t'(PROG_MS - 1)) begin
        prog_next = 1'b0; // RQ16
      end
    end else if (mem_stop_write && gate && !wp_s) begin
      prog_next     = 1'b1; // RQ16
      prog_cnt_next = '0;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      prog_reg     <= 1'b0;
      prog_cnt_reg <= '0;
    end else begin
      prog_reg     <= prog_next;
      prog_cnt_reg <= prog_cnt_next;
    end
  end
  always_comb begin
    mem_busy        = prog_reg;
    mem_access_ok   = gate && !prog_reg; // RQ15 RQ16
    mem_write_ok    = mem_access_ok && !wp_s; // RQ12 RQ13 RQ14
    mem_data_ack_ok = mem_access_ok && !(wp_s && mem_data_byte); // RQ18
  end

  // checks
  sequence s_supply_low;
    !sup_ok;
  endsequence
  sequence s_held;
    rst_hi_oe && rst_lo_n_oe;
  endsequence
  property p_low_supply_resets;
    @(posedge clk) disable iff (!rst_n)
      s_supply_low |=> s_held;
  endproperty
  a_low_supply_resets: assert property (p_low_supply_resets) // RQ1
    else $error("reset not driven with low supply");
  property p_no_early_release;
    @(posedge clk) disable iff (!rst_n)
      $rose(st_reg == SRW_TIMEOUT) |-> tmo_reg == '0;
  endproperty
  a_no_early_release: assert property (p_no_early_release) // RQ2
    else $error("timeout did not start at zero");
  property p_release_after_count;
    @(posedge clk) disable iff (!rst_n)
      $fell(rst_act) |-> $past(tmo_reg) == srw_ms_t'(PURST_MS - 1) ||
        $past(st_reg) == SRW_RUN;
  endproperty
  a_release_after_count: assert property (p_release_after_count) // RQ2
    else $error("reset released before timeout");
  property p_od_levels;
    @(posedge clk) disable iff (!rst_n)
      rst_hi_out && !rst_lo_n_out && (rst_act || !(rst_hi_oe || rst_lo_n_oe));
  endproperty
  a_od_levels: assert property (p_od_levels) // RQ3
    else $error("open drain drives wrong level");
  property p_edge_restart;
    @(posedge clk) disable iff (!rst_n)
      (hi_rise || lo_fall) |=> rst_act;
  endproperty
  a_edge_restart: assert property (p_edge_restart) // RQ4
    else $error("manual edge did not start reset");
  property p_wd_held;
    @(posedge clk) disable iff (!rst_n)
      rst_act |-> wd_reg == '0;
  endproperty
  a_wd_held: assert property (p_wd_held) // RQ9
    else $error("watchdog counted during reset");
  property p_wd_clear;
    @(posedge clk) disable iff (!rst_n)
      (wdi_edge && st_reg == SRW_RUN) |=> wd_reg == '0;
  endproperty
  a_wd_clear: assert property (p_wd_clear) // RQ8
    else $error("watchdog not cleared by edge");
  property p_no_ack_in_reset;
    @(posedge clk) disable iff (!rst_n)
      rst_act |-> !mem_access_ok && !mem_write_ok;
  endproperty
  a_no_ack_in_reset: assert property (p_no_ack_in_reset) // RQ15
    else $error("access allowed during reset");
  property p_protect;
    @(posedge clk) disable iff (!rst_n)
      wp_s |-> !mem_write_ok;
  endproperty
  a_protect: assert property (p_protect) // RQ12
    else $error("write allowed while protected");
  property p_busy_blocks;
    @(posedge clk) disable iff (!rst_n)
      mem_busy |-> !mem_access_ok;
  endproperty
  a_busy_blocks: assert property (p_busy_blocks) // RQ16
    else $error("bus active during program cycle");
  property p_ext_hold;
    @(posedge clk) disable iff (!rst_n)
      (hi_ext || lo_ext) |=> rst_act;
  endproperty
  a_ext_hold: assert property (p_ext_hold) // RQ6
    else $error("external reset level not held");
  property p_supply_delay;
    @(posedge clk) disable iff (!rst_n)
      $fell(supply_good) |-> ##[1:4] s_held;
  endproperty
  a_supply_delay: assert property (p_supply_delay) // RQ11
    else $error("reset late after supply drop");
endmodule // srw_supervisor
`default_nettype wire

// ### sim/srw_host_model.sv
// srw_host_model.sv: host side model, kicks watchdog, forces reset pins
// assumes pull-down on the high reset pin and pull-up on the low one
`default_nettype none
module srw_host_model (
  input  wire logic clk,
  input  wire logic kick_en,
  input  wire logic force_rst,
  input  wire logic force_pin,
  input  wire logic rst_hi_out,
  input  wire logic rst_hi_oe,
  input  wire logic rst_lo_n_out,
  input  wire logic rst_lo_n_oe,
  output logic      rst_hi_pin,
  output logic      rst_lo_n_pin,
  output logic      kick
);
  timeunit 1ns;
  timeprecision 1ns;
  int   cnt = 0;
  logic kick_reg = 1'b0;
  // toggles well inside the watchdog period
  always @(posedge clk) begin
    cnt <= (cnt == 99) ? 0 : cnt + 1;
    if (kick_en && cnt == 99) kick_reg <= #1 ~kick_reg;
  end
  assign kick = kick_reg;
  // wired levels: any driver wins, resistors give the idle level
  assign rst_hi_pin = (rst_hi_oe && rst_hi_out) || (force_rst && !force_pin);
  assign rst_lo_n_pin = !((rst_lo_n_oe && !rst_lo_n_out)
                          || (force_rst && force_pin));
endmodule // srw_host_model
`default_nettype wire

// ### sim/srw_supervisor_tb.sv
// srw_supervisor_tb.sv: self-checking bench for the supervisor
// assumes shortened tick and timeouts set through parameters
`default_nettype none
module srw_supervisor_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int P = 10;
  localparam int PU = 20;
  localparam int WD = 40;
  localparam int PG = 5;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic supply_good = 1'b0;
  logic kick_en = 1'b1;
  logic force_rst = 1'b0;
  logic force_pin = 1'b0;
  logic write_protect = 1'b0;
  logic mem_stop_write = 1'b0;
  logic mem_data_byte = 1'b0;
  logic rst_hi_out, rst_hi_oe, rst_lo_n_out, rst_lo_n_oe;
  logic rst_hi_pin, rst_lo_n_pin, kick;
  logic mem_access_ok, mem_data_ack_ok, mem_write_ok, mem_busy;
  int   mismatches = 0;
  int   samples_checked = 0;
  always #5 clk = ~clk;
  srw_supervisor #(.PRESCALE(P), .PURST_MS(PU), .WDOG_MS(WD),
                   .PROG_MS(PG)) DUT (
    .clk(clk), .rst_n(rst_n), .supply_good(supply_good),
    .rst_hi_in(rst_hi_pin), .rst_hi_out(rst_hi_out), .rst_hi_oe(rst_hi_oe),
    .rst_lo_n_in(rst_lo_n_pin), .rst_lo_n_out(rst_lo_n_out),
    .rst_lo_n_oe(rst_lo_n_oe), .watchdog_kick_input(kick),
    .write_protect(write_protect), .mem_stop_write(mem_stop_write),
    .mem_data_byte(mem_data_byte), .mem_access_ok(mem_access_ok),
    .mem_data_ack_ok(mem_data_ack_ok), .mem_write_ok(mem_write_ok),
    .mem_busy(mem_busy));
  srw_host_model host (
    .clk(clk), .kick_en(kick_en), .force_rst(force_rst),
    .force_pin(force_pin), .rst_hi_out(rst_hi_out), .rst_hi_oe(rst_hi_oe),
    .rst_lo_n_out(rst_lo_n_out), .rst_lo_n_oe(rst_lo_n_oe),
    .rst_hi_pin(rst_hi_pin), .rst_lo_n_pin(rst_lo_n_pin), .kick(kick));
  task automatic stop_test();
    if (mismatches == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic check(input logic seen, input logic exp, input string m);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // counts cycles until the OR of the drives on both reset pins reaches lvl
  task automatic wait_oe(input logic lvl, output int n);
    n = 0;
    while ((rst_hi_oe || rst_lo_n_oe) !== lvl) begin
      cyc(1);
      n++;
      if (n > 2000) begin
        check(1'b0, 1'b1, "wait timed out");
        stop_test();
      end
    end
  endtask
  task automatic t_powerup();
    int n;
    check(rst_hi_oe, 1'b1, "high reset off");
    check(rst_lo_n_oe, 1'b1, "low reset off");
    check(mem_access_ok, 1'b0, "access in reset");
    check(mem_write_ok, 1'b0, "write at low supply");
    supply_good = 1'b1;
    wait_oe(1'b0, n);
    check(n >= (PU-1)*P && n <= (PU+1)*P+8, 1'b1, "power-up length");
    cyc(1);
    check(rst_lo_n_oe, 1'b0, "low reset kept");
    check(rst_hi_pin, 1'b0, "high pin idle");
    check(rst_lo_n_pin, 1'b1, "low pin idle");
  endtask
  task automatic t_brownout();
    int n;
    supply_good = 1'b0;
    wait_oe(1'b1, n);
    check(n <= 500, 1'b1, "threshold delay");
    check(rst_lo_n_oe, 1'b1, "low reset at brownout");
    check(mem_write_ok, 1'b0, "write at brownout");
    cyc(50);
    supply_good = 1'b1;
    wait_oe(1'b0, n);
  endtask
  task automatic t_manual(input logic pin);
    int n;
    // let the readback of the just released drive settle first
    cyc(20);
    force_pin = pin;
    force_rst = 1'b1;
    cyc(9);
    force_rst = 1'b0;
    cyc(40);
    check(rst_hi_oe, 1'b0, "glitch taken");
    force_rst = 1'b1;
    wait_oe(1'b1, n);
    cyc(60);
    check(rst_hi_pin, 1'b1, "high pin not in reset");
    check(rst_lo_n_pin, 1'b0, "low pin not in reset");
    check(pin ? rst_hi_oe : rst_lo_n_oe, 1'b1, "forced reset lost");
    force_rst = 1'b0;
    wait_oe(1'b0, n);
    check(n >= (PU-1)*P && n <= (PU+1)*P+20, 1'b1, "manual len");
  endtask
  task automatic t_watchdog();
    int n;
    cyc(2*WD*P);
    check(rst_hi_oe, 1'b0, "reset despite kicks");
    @(kick);
    kick_en = 1'b0;
    wait_oe(1'b1, n);
    check(n >= (WD-1)*P && n <= (WD+1)*P+8, 1'b1, "watchdog len");
    check(mem_access_ok, 1'b0, "access in reset");
    wait_oe(1'b0, n);
    wait_oe(1'b1, n);
    check(n >= (WD-1)*P && n <= (WD+1)*P+8, 1'b1, "count in reset");
    kick_en = 1'b1;
    wait_oe(1'b0, n);
  endtask
  task automatic t_memory();
    int n;
    mem_data_byte = 1'b1;
    cyc(3);
    check(mem_access_ok, 1'b1, "address refused");
    check(mem_data_ack_ok, 1'b1, "data refused");
    check(mem_write_ok, 1'b1, "write refused");
    write_protect = 1'b1;
    cyc(4);
    check(mem_write_ok, 1'b0, "protected write");
    check(mem_data_ack_ok, 1'b0, "protected data ack");
    mem_data_byte = 1'b0;
    cyc(1);
    check(mem_data_ack_ok, 1'b1, "protected address ack");
    mem_stop_write = 1'b1;
    cyc(1);
    mem_stop_write = 1'b0;
    check(mem_busy, 1'b0, "program while protected");
    write_protect = 1'b0;
    cyc(4);
    mem_stop_write = 1'b1;
    cyc(1);
    mem_stop_write = 1'b0;
    check(mem_busy, 1'b1, "no program cycle");
    check(mem_access_ok, 1'b0, "address in cycle");
    n = 0;
    while (mem_busy === 1'b1 && n < 2000) begin
      cyc(1);
      n++;
    end
    check(n >= (PG-1)*P && n <= (PG+1)*P, 1'b1, "program length");
    check(mem_access_ok, 1'b1, "address after cycle");
  endtask
  initial begin
    cyc(3);
    rst_n = 1'b1;
    t_powerup();
    t_brownout();
    t_manual(1'b0);
    t_manual(1'b1);
    t_watchdog();
    // memory touched only long after the supply settled
    t_memory();
    stop_test();
  end
endmodule // srw_supervisor_tb
`default_nettype wire
